// ### core/comparator_event_pkg.sv
// constants, field layouts and carriers of the comparator event control block
// assumes one 20 MHz clock and a plain byte-wide register port
// Behaviour
// - raw result high when positive exceeds negative
// - off bit removes comparator power
// - select bit swaps pin for fixed reference
// - result bit passes a synchroniser first
// - selected event on synced output sets flag
// - interrupt requested only when flag and enables
// - vector taken or written one clears flag
// - route enable feeds result to capture
// - mode: toggle, reserved, falling, rising
// - buffer off bits force pin reads zero
package comparator_event_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [3:0] CTRL_STATUS_ADDR   = 4'h0;
	localparam logic [3:0] INPUT_DISABLE_ADDR = 4'h1;

	localparam int OFF_POS       = 7;
	localparam int BANDGAP_POS   = 6;
	localparam int RESULT_POS    = 5;
	localparam int FLAG_POS      = 4;
	localparam int IRQ_EN_POS    = 3;
	localparam int CAPTURE_POS   = 2;
	localparam int MODE_HI_POS   = 1;
	localparam int MODE_LO_POS   = 0;
	localparam int NEG_OFF_POS   = 1;
	localparam int POS_OFF_POS   = 0;

	localparam logic [7:0] CTRL_RESET    = 8'h00;
	localparam logic [1:0] DISABLE_RESET = 2'h0;

	// ----------------------------------------------------------------
	// event modes
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_TOGGLE   = 2'h0;
	localparam logic [1:0] MODE_RESERVED = 2'h1;
	localparam logic [1:0] MODE_FALLING  = 2'h2;
	localparam logic [1:0] MODE_RISING   = 2'h3;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic pin_above_neg;
		logic ref_above_neg;
	} analog_in_t;

	typedef struct packed {
		logic power_down;
		logic bandgap_sel;
	} analog_ctrl_t;

	typedef struct packed {
		logic       off;
		logic       bandgap;
		logic       flag;
		logic       irq_en;
		logic       capture_en;
		logic [1:0] mode;
		logic [1:0] buf_off;
		logic       raw;
		logic       sync1;
		logic       sync2;
		logic       prev;
		logic       irq;
		logic       capture;
		logic [1:0] pin_read;
		logic [7:0] rdata;
	} state_t;

endpackage

// ### core/comparator_event_control.sv
// control, synchroniser and edge-event logic around an analog comparator
// assumes the analog core and timer front end sit outside, all inputs synchronous
`timescale 1ns/10ps
module comparator_event_control
	import comparator_event_pkg::*;
(
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic [3:0]   addr,
	input  wire logic [7:0]   wdata,
	input  wire logic         wr_en,
	input  wire logic         rd_en,
	output logic      [7:0]   rdata,
	input  wire analog_in_t   analog_in,
	output analog_ctrl_t      analog_ctrl,
	output logic              raw_result,
	input  wire logic         global_irq_enable,
	input  wire logic         vector_taken,
	output logic              irq_request,
	output logic              capture_input,
	input  wire logic [1:0]   pin_digital,
	output logic      [1:0]   pin_read
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	state_t st;
	state_t next_st;
	logic   raw_now;
	logic   edge_event;
	logic   ctrl_wr;
	logic   dis_wr;

	function automatic logic event_hit(input logic [1:0] mode, input logic cur, input logic prev);
		case (mode)
			MODE_TOGGLE:  event_hit = cur ^ prev;
			MODE_FALLING: event_hit = !cur && prev;
			MODE_RISING:  event_hit = cur && !prev;
			default:      event_hit = 1'b0;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		ctrl_wr = wr_en && (addr == CTRL_STATUS_ADDR);
		dis_wr  = wr_en && (addr == INPUT_DISABLE_ADDR);

		// a powered-down comparator reads low so its output stays defined
		raw_now = !st.off && (st.bandgap ? analog_in.ref_above_neg : analog_in.pin_above_neg);
		next_st.raw = raw_now;

		// two stages; only the second one is looked at
		next_st.sync1 = raw_now;
		next_st.sync2 = st.sync1;
		next_st.prev  = st.sync2;

		// the interrupt enable plays no part here, polling still works
		edge_event = event_hit(st.mode, st.sync2, st.prev);

		if (ctrl_wr) begin
			next_st.off        = wdata[OFF_POS];
			next_st.bandgap    = wdata[BANDGAP_POS];
			next_st.irq_en     = wdata[IRQ_EN_POS];
			next_st.capture_en = wdata[CAPTURE_POS];
			next_st.mode       = {wdata[MODE_HI_POS], wdata[MODE_LO_POS]};
		end
		if (dis_wr) begin
			next_st.buf_off = {wdata[NEG_OFF_POS], wdata[POS_OFF_POS]};
		end

		// set wins over either clear so no event is lost
		if (edge_event) begin
			next_st.flag = 1'b1;
		end else if (vector_taken || (ctrl_wr && wdata[FLAG_POS])) begin
			next_st.flag = 1'b0;
		end

		next_st.irq      = st.flag && st.irq_en && global_irq_enable;
		next_st.capture  = st.capture_en && st.sync2;
		next_st.pin_read = pin_digital & ~st.buf_off;

		next_st.rdata = 8'h00;
		if (rd_en) begin
			case (addr)
				CTRL_STATUS_ADDR: begin
					next_st.rdata = {st.off, st.bandgap, st.sync2, st.flag,
						st.irq_en, st.capture_en, st.mode};
				end
				INPUT_DISABLE_ADDR: begin
					next_st.rdata = {6'h00, st.buf_off};
				end
				default: begin
					next_st.rdata = 8'h00;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st            <= '0;
			st.off        <= CTRL_RESET[OFF_POS];
			st.bandgap    <= CTRL_RESET[BANDGAP_POS];
			st.flag       <= CTRL_RESET[FLAG_POS];
			st.irq_en     <= CTRL_RESET[IRQ_EN_POS];
			st.capture_en <= CTRL_RESET[CAPTURE_POS];
			st.mode       <= CTRL_RESET[MODE_HI_POS:MODE_LO_POS];
			st.buf_off    <= DISABLE_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign rdata                   = st.rdata;
	assign analog_ctrl.power_down  = st.off;
	assign analog_ctrl.bandgap_sel = st.bandgap;
	assign raw_result              = st.raw;
	assign irq_request             = st.irq;
	assign capture_input           = st.capture;
	assign pin_read                = st.pin_read;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_reference_path;
		@(posedge mclk) disable iff (!rst_n)
		(!st.off && st.bandgap) |=> (raw_result == $past(analog_in.ref_above_neg));
	endproperty
	a_reference_path: assert property (p_reference_path) else $error("raw result not from reference");

	property p_pin_path;
		@(posedge mclk) disable iff (!rst_n)
		(!st.off && !st.bandgap) |=> (raw_result == $past(analog_in.pin_above_neg));
	endproperty
	a_pin_path: assert property (p_pin_path) else $error("raw result not from pin");

	property p_power_off;
		@(posedge mclk) disable iff (!rst_n)
		(st.off && !(ctrl_wr && !wdata[OFF_POS]))
			|=> (!raw_result && analog_ctrl.power_down);
	endproperty
	a_power_off: assert property (p_power_off) else $error("comparator active while off");

	property p_sync_delay;
		@(posedge mclk) disable iff (!rst_n)
		rst_n [*3] |-> (st.sync2 == $past(raw_now, 2));
	endproperty
	a_sync_delay: assert property (p_sync_delay) else $error("result bit latency wrong");

	property p_rise_sets;
		@(posedge mclk) disable iff (!rst_n)
		(st.mode == MODE_RISING && st.sync2 && !st.prev) |=> st.flag;
	endproperty
	a_rise_sets: assert property (p_rise_sets) else $error("rising edge did not set flag");

	property p_fall_only;
		@(posedge mclk) disable iff (!rst_n)
		(st.mode == MODE_FALLING && !st.flag && !(ctrl_wr && wdata[1:0] != MODE_FALLING)
			&& !(!st.sync2 && st.prev)) |=> !st.flag;
	endproperty
	a_fall_only: assert property (p_fall_only) else $error("flag set without falling edge");

	property p_reserved;
		@(posedge mclk) disable iff (!rst_n)
		(st.mode == MODE_RESERVED && !st.flag) |=> !st.flag;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved mode set flag");

	property p_irq_gate;
		@(posedge mclk) disable iff (!rst_n)
		irq_request |-> $past(st.flag && st.irq_en && global_irq_enable);
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("interrupt without cause");

	property p_vector_clear;
		@(posedge mclk) disable iff (!rst_n)
		(vector_taken && !edge_event) |=> !st.flag;
	endproperty
	a_vector_clear: assert property (p_vector_clear) else $error("flag survived vector");

	property p_no_route;
		@(posedge mclk) disable iff (!rst_n)
		!st.capture_en |=> !capture_input;
	endproperty
	a_no_route: assert property (p_no_route) else $error("capture fed while unrouted");

	property p_buffer_off;
		@(posedge mclk) disable iff (!rst_n)
		st.buf_off[POS_OFF_POS] |=> !pin_read[POS_OFF_POS];
	endproperty
	a_buffer_off: assert property (p_buffer_off) else $error("disabled pin read high");

	// ----------------------------------------------------------------
	// checks: edge events
	// ----------------------------------------------------------------
	property p_toggle_sets;
		@(posedge mclk) disable iff (!rst_n)
		(st.mode == MODE_TOGGLE && (st.sync2 != st.prev)) |=> st.flag;
	endproperty
	a_toggle_sets: assert property (p_toggle_sets) else $error("toggle did not set flag");

	property p_fall_sets;
		@(posedge mclk) disable iff (!rst_n)
		(st.mode == MODE_FALLING && !st.sync2 && st.prev) |=> st.flag;
	endproperty
	a_fall_sets: assert property (p_fall_sets) else $error("falling edge did not set flag");

	property p_rise_only;
		@(posedge mclk) disable iff (!rst_n)
		(st.mode == MODE_RISING && !st.flag && !(st.sync2 && !st.prev)) |=> !st.flag;
	endproperty
	a_rise_only: assert property (p_rise_only) else $error("flag set without rising edge");

	property p_edge_history;
		@(posedge mclk) disable iff (!rst_n)
		rst_n |=> (st.prev == $past(st.sync2));
	endproperty
	a_edge_history: assert property (p_edge_history) else $error("edge history sample stale");

	property p_enable_ignored;
		@(posedge mclk) disable iff (!rst_n)
		(edge_event && !st.irq_en) |=> st.flag;
	endproperty
	a_enable_ignored: assert property (p_enable_ignored) else $error("masked event lost");

	property p_reserved_quiet;
		@(posedge mclk) disable iff (!rst_n)
		(st.mode == MODE_RESERVED) |-> !edge_event;
	endproperty
	a_reserved_quiet: assert property (p_reserved_quiet) else $error("reserved mode raised event");

	property p_mode_hold;
		@(posedge mclk) disable iff (!rst_n)
		!ctrl_wr |=> $stable(st.mode);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode changed without write");

	// ----------------------------------------------------------------
	// checks: flag, interrupt and capture
	// ----------------------------------------------------------------
	property p_no_spurious_flag;
		@(posedge mclk) disable iff (!rst_n)
		(!st.flag && !edge_event) |=> !st.flag;
	endproperty
	a_no_spurious_flag: assert property (p_no_spurious_flag) else $error("flag set without event");

	property p_write_clears;
		@(posedge mclk) disable iff (!rst_n)
		(ctrl_wr && wdata[FLAG_POS] && !edge_event) |=> !st.flag;
	endproperty
	a_write_clears: assert property (p_write_clears) else $error("flag survived write of one");

	property p_write_zero_keeps;
		@(posedge mclk) disable iff (!rst_n)
		(st.flag && !vector_taken && !(ctrl_wr && wdata[FLAG_POS])) |=> st.flag;
	endproperty
	a_write_zero_keeps: assert property (p_write_zero_keeps) else $error("flag lost without clear");

	property p_irq_raise;
		@(posedge mclk) disable iff (!rst_n)
		(st.flag && st.irq_en && global_irq_enable) |=> irq_request;
	endproperty
	a_irq_raise: assert property (p_irq_raise) else $error("interrupt not requested");

	property p_irq_enable_off;
		@(posedge mclk) disable iff (!rst_n)
		!st.irq_en |=> !irq_request;
	endproperty
	a_irq_enable_off: assert property (p_irq_enable_off) else $error("interrupt while disabled");

	property p_route_on;
		@(posedge mclk) disable iff (!rst_n)
		st.capture_en |=> (capture_input == $past(st.sync2));
	endproperty
	a_route_on: assert property (p_route_on) else $error("capture not fed from result");

	// ----------------------------------------------------------------
	// checks: register port and pins
	// ----------------------------------------------------------------
	property p_off_write;
		@(posedge mclk) disable iff (!rst_n)
		ctrl_wr |=> (analog_ctrl.power_down == $past(wdata[OFF_POS]));
	endproperty
	a_off_write: assert property (p_off_write) else $error("off bit not taken from write");

	property p_bandgap_write;
		@(posedge mclk) disable iff (!rst_n)
		ctrl_wr |=> (analog_ctrl.bandgap_sel == $past(wdata[BANDGAP_POS]));
	endproperty
	a_bandgap_write: assert property (p_bandgap_write) else $error("select bit not taken from write");

	property p_result_bit;
		@(posedge mclk) disable iff (!rst_n)
		(rd_en && addr == CTRL_STATUS_ADDR) |=> (rdata[RESULT_POS] == $past(st.sync2));
	endproperty
	a_result_bit: assert property (p_result_bit) else $error("result bit not synchronised value");

	property p_neg_buffer_off;
		@(posedge mclk) disable iff (!rst_n)
		st.buf_off[NEG_OFF_POS] |=> !pin_read[NEG_OFF_POS];
	endproperty
	a_neg_buffer_off: assert property (p_neg_buffer_off) else $error("disabled negative pin read high");

	property p_buffer_on;
		@(posedge mclk) disable iff (!rst_n)
		!st.buf_off[POS_OFF_POS] |=> (pin_read[POS_OFF_POS] == $past(pin_digital[POS_OFF_POS]));
	endproperty
	a_buffer_on: assert property (p_buffer_on) else $error("enabled pin not passed through");

endmodule // comparator_event_control

// ### verification/analog_core_model.sv
// behavioural analog comparator core driven by millivolt levels
// assumes the control block gives power and reference select
`timescale 1ns/10ps
module analog_core_model
	import comparator_event_pkg::*;
#(
	parameter int SETTLE = 2
)
(
	input  wire logic         mclk,
	input  wire analog_ctrl_t analog_ctrl,
	input  wire logic [9:0]   pos_mv,
	input  wire logic [9:0]   neg_mv,
	input  wire logic [9:0]   ref_mv,
	output analog_in_t        analog_in
);
	logic noise  = 1'b0;
	int   settle = 0;
	// ----------------------------------------------------------------
	// outcomes
	// ----------------------------------------------------------------
	always @(posedge mclk) begin
		noise  <= ~noise;
		settle <= analog_ctrl.bandgap_sel ? (settle < SETTLE ? settle + 1 : settle) : 0;
	end
	always_comb begin
		analog_in.pin_above_neg = pos_mv > neg_mv;
		// an unsettled reference gives the wrong answer on purpose
		analog_in.ref_above_neg = (ref_mv > neg_mv) ^ (settle < SETTLE);
		// unpowered core: outputs mean nothing, so they wander
		if (analog_ctrl.power_down) begin
			analog_in = {noise, ~noise};
		end
	end
endmodule // analog_core_model

// ### verification/tb.sv
// self-checking bench of the comparator event control block
// assumes the analog core model turns millivolt levels into outcomes
`timescale 1ns/10ps
module tb
	import comparator_event_pkg::*;
;
	typedef struct {logic [1:0] mode; logic from; logic to; logic flag;} row_t;
	logic         mclk, rst_n, wr_en, rd_en, global_irq_enable, vector_taken;
	logic         raw_result, irq_request, capture_input;
	logic [3:0]   addr;
	logic [7:0]   wdata, rdata, v;
	logic [1:0]   pin_digital, pin_read;
	logic [9:0]   pos_mv, neg_mv, ref_mv;
	analog_in_t   analog_in;
	analog_ctrl_t analog_ctrl;
	int           miscompares = 0;
	int           comparisons = 0;
	row_t rows [8] = '{'{MODE_TOGGLE, 1'b0, 1'b1, 1'b1}, '{MODE_TOGGLE, 1'b1, 1'b0, 1'b1},
		'{MODE_RESERVED, 1'b0, 1'b1, 1'b0}, '{MODE_RESERVED, 1'b1, 1'b0, 1'b0},
		'{MODE_FALLING, 1'b1, 1'b0, 1'b1}, '{MODE_FALLING, 1'b0, 1'b1, 1'b0},
		'{MODE_RISING, 1'b0, 1'b1, 1'b1}, '{MODE_RISING, 1'b1, 1'b0, 1'b0}};
	comparator_event_control u_comparator_event_control (.mclk(mclk), .rst_n(rst_n), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .analog_in(analog_in),
		.analog_ctrl(analog_ctrl), .raw_result(raw_result), .global_irq_enable(global_irq_enable),
		.vector_taken(vector_taken), .irq_request(irq_request), .capture_input(capture_input),
		.pin_digital(pin_digital), .pin_read(pin_read));
	analog_core_model u_analog_core_model (.mclk(mclk), .analog_ctrl(analog_ctrl), .pos_mv(pos_mv),
		.neg_mv(neg_mv), .ref_mv(ref_mv), .analog_in(analog_in));
	// ----------------------------------------------------------------
	// bus and compare helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string name);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr  <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge mclk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge mclk);
		addr  <= a;
		rd_en <= 1'b1;
		@(posedge mclk);
		rd_en <= 1'b0;
		@(negedge mclk);
		v = rdata;
	endtask
	task automatic complete_run;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	initial begin
		cyc(3000);
		miscompares++;
		complete_run();
	end
	initial begin
		{rst_n, wr_en, rd_en, vector_taken, addr, wdata} = '0;
		global_irq_enable = 1'b1;
		pin_digital = 2'h3;
		pos_mv = 10'h190;
		neg_mv = 10'h1F4;
		ref_mv = 10'h258;
		cyc(2);
		rst_n <= 1'b1;
		rd(CTRL_STATUS_ADDR);
		check(v, CTRL_RESET, "ctrl reset");
		rd(4'hF);
		check(v, 8'h00, "unmapped");
		wr(INPUT_DISABLE_ADDR, 8'hFF);
		rd(INPUT_DISABLE_ADDR);
		check(v, 8'h03, "disable");
		@(negedge mclk);
		check(rdata, 8'h00, "read idle");
		check({6'h00, pin_read}, 8'h00, "pins off");
		wr(INPUT_DISABLE_ADDR, 8'h01);
		cyc(2);
		check({6'h00, pin_read}, 8'h02, "pin one off");
		$display("test registers done");
		foreach (rows[i]) begin
			wr(CTRL_STATUS_ADDR, {6'h00, rows[i].mode});
			pos_mv <= rows[i].from ? 10'h258 : 10'h190;
			cyc(5);
			wr(CTRL_STATUS_ADDR, {6'h04, rows[i].mode});
			pos_mv <= rows[i].to ? 10'h258 : 10'h190;
			cyc(5);
			rd(CTRL_STATUS_ADDR);
			check(v, {2'h0, rows[i].to, rows[i].flag, 2'h0, rows[i].mode}, "mode row");
			check({7'h00, irq_request}, 8'h00, "irq masked");
		end
		$display("test modes done");
		wr(CTRL_STATUS_ADDR, 8'h1B);
		pos_mv <= 10'h258;
		cyc(5);
		check({7'h00, irq_request}, 8'h01, "irq on");
		global_irq_enable <= 1'b0;
		cyc(2);
		check({7'h00, irq_request}, 8'h00, "irq global off");
		global_irq_enable <= 1'b1;
		vector_taken <= 1'b1;
		cyc(1);
		vector_taken <= 1'b0;
		rd(CTRL_STATUS_ADDR);
		check(v & 8'h10, 8'h00, "vector clear");
		pos_mv <= 10'h190;
		cyc(5);
		pos_mv <= 10'h258;
		cyc(5);
		wr(CTRL_STATUS_ADDR, 8'h0B);
		rd(CTRL_STATUS_ADDR);
		check(v & 8'h10, 8'h10, "write zero keeps");
		wr(CTRL_STATUS_ADDR, 8'h13);
		rd(CTRL_STATUS_ADDR);
		check(v & 8'h10, 8'h00, "write one clears");
		$display("test irq done");
		wr(CTRL_STATUS_ADDR, 8'h04);
		cyc(3);
		check({7'h00, capture_input}, 8'h01, "capture on");
		wr(CTRL_STATUS_ADDR, 8'h00);
		cyc(3);
		check({7'h00, capture_input}, 8'h00, "capture off");
		pos_mv <= 10'h190;
		wr(CTRL_STATUS_ADDR, 8'h40);
		cyc(5);
		check({6'h00, analog_ctrl}, 8'h01, "ref select");
		check({7'h00, raw_result}, 8'h01, "ref result");
		wr(CTRL_STATUS_ADDR, 8'hC0);
		cyc(3);
		check({6'h00, analog_ctrl}, 8'h03, "power down");
		check({7'h00, raw_result}, 8'h00, "off result");
		$display("test analog done");
		rst_n <= 1'b0;
		cyc(2);
		rst_n <= 1'b1;
		rd(CTRL_STATUS_ADDR);
		check(v, CTRL_RESET, "ctrl second reset");
		$display("test second reset done");
		complete_run();
	end
endmodule // tb
